// ==== include/nvc_pkg.sv ====
// types shared by the eeprom access controller
`default_nettype none
package nvc_pkg;
  typedef enum logic [1:0] {
    NVC_MODE_ATOMIC = 2'h0,
    NVC_MODE_ERASE = 2'h1,
    NVC_MODE_WRITE = 2'h2,
    NVC_MODE_RSVD = 2'h3
  } nvc_mode_e;
  typedef enum logic [2:0] {
    NVC_ST_IDLE = 3'h1,
    NVC_ST_ERASE = 3'h2,
    NVC_ST_WRITE = 3'h4
  } nvc_state_e;
endpackage
`default_nettype wire

// ==== include/nvc_regs.svh ====
// register map, field positions and timing constants of the eeprom access controller
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH
`define NVC_IO_CONTROL 6'h1C
`define NVC_IO_DATA 6'h1D
`define NVC_IO_ADDRESS 6'h1E
`define NVC_DS_OFFSET 7'h20
`define NVC_BIT_READ 0
`define NVC_BIT_GO 1
`define NVC_BIT_ARM 2
`define NVC_BIT_RIE 3
`define NVC_MODE_LO 4
`define NVC_MODE_HI 5
`define NVC_ARM_CYCLES 3'h4
`define NVC_GO_STALL 3'h2
`define NVC_READ_STALL 3'h4
`define NVC_ATOMIC_US 3400
`define NVC_SPLIT_US 1800
`define NVC_OSC_KHZ 8000
`define NVC_DATA_RESET 8'h00
`endif

// ==== rtl/nvc_eeprom_ctrl.sv ====
// eeprom access controller: address, data and control registers, 64-byte array
//
// Function
// R1 - erase-only mode erases just the addressed byte, no write phase
// R2 - write-only mode programs data without erasing first
// R3 - mode 00 atomic 3.4 ms, 01 erase and 10 write 1.8 ms, 11 reserved
// R4 - go bit reads one while programming, cleared when time elapses
// R5 - while programming, every other eeprom operation is refused
// R6 - software must erase before write-only, else byte content is lost
// R7 - arm bit self-clears four cycles after software sets it
// R8 - go starts programming only while arm bit still set
// R9 - mode field writes are ignored while go is set
// R10 - reset forces mode to 00 unless programming is under way
// R11 - ready interrupt is a level while enabled, global enable set, not busy
// R12 - setting go stalls the cpu for two cycles
// R13 - read strobe fetches the byte at once and stalls four cycles
// R14 - while programming, reads are blocked and address cannot change
// R15 - six-bit address, upper two bits read zero, reset value undefined
// R16 - data register feeds writes and receives read results
// R17 - reset during programming lets the operation finish; nvData still resets to 00, so atomic and write-only modes program 00
// R18 - programming time comes from the calibrated oscillator
// R19 - software polls go before reading and sets address first
// R20 - registers at io 1C, 1D, 1E; data-space view adds 20
// R21 - go with reserved mode does nothing and clears at once; here it still clears the arm bit and stalls the cpu two cycles
`default_nettype none
`include "nvc_regs.svh"
module nvc_eeprom_ctrl #(
  parameter int DEPTH = 64,
  parameter int OSC_KHZ = `NVC_OSC_KHZ
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic oscTick,
  input wire logic globalIrqEnable,
  input wire logic [6:0] ioAddr,
  input wire logic dataSpace,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  output logic [7:0] ioRdata,
  output logic cpuStall,
  output logic readyIrq
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH != 64) $error("address register is six bits wide");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  logic [AW-1:0] nvAddress;
  logic [7:0] nvData;
  logic [1:0] programModeField;
  logic readyIrqEnable;
  logic programArmBit;
  logic [2:0] armCount;
  nvc_pkg::nvc_state_e state;
  nvc_pkg::nvc_state_e next_state;
  logic [7:0] mem [DEPTH];

  wire logic [6:0] base = dataSpace ? `NVC_DS_OFFSET : 7'h00; // R20
  wire logic selCtrl = ioAddr == (base + {1'b0, `NVC_IO_CONTROL}); // R20
  wire logic selData = ioAddr == (base + {1'b0, `NVC_IO_DATA}); // R20
  wire logic selAddr = ioAddr == (base + {1'b0, `NVC_IO_ADDRESS}); // R20
  wire logic wrCtrl = ioWrite && selCtrl;
  wire logic busy = state != nvc_pkg::NVC_ST_IDLE;
  wire logic goWrite = wrCtrl && ioWdata[`NVC_BIT_GO] && !busy; // R5
  wire logic goValid = goWrite && programArmBit; // R8
  wire logic goReserved = programModeField == nvc_pkg::NVC_MODE_RSVD;
  wire logic goStart = goValid && !goReserved; // R21
  wire logic modeWrite = wrCtrl && !busy && !goWrite; // R9
  wire logic timerClear = rst && !busy; // R17
  wire logic readStrobe = wrCtrl && ioWdata[`NVC_BIT_READ] && !busy; // R5 R14
  wire logic opDone;
  wire logic [7:0] ctrlRead = {2'b00, programModeField, readyIrqEnable,
                               programArmBit, busy, 1'b0}; // R4
  wire logic [7:0] addrRead = {{(8-AW){1'b0}}, nvAddress}; // R15
  wire logic [7:0] next_rdata = selCtrl ? ctrlRead : selData ? nvData :
                                selAddr ? addrRead : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // programming sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      nvc_pkg::NVC_ST_IDLE: begin
        if (goStart) begin
          unique case (programModeField)
            nvc_pkg::NVC_MODE_WRITE: next_state = nvc_pkg::NVC_ST_WRITE; // R2
            default: next_state = nvc_pkg::NVC_ST_ERASE; // R1 R3
          endcase
        end
      end
      nvc_pkg::NVC_ST_ERASE: if (opDone) next_state = nvc_pkg::NVC_ST_IDLE;
      nvc_pkg::NVC_ST_WRITE: if (opDone) next_state = nvc_pkg::NVC_ST_IDLE;
      default: next_state = nvc_pkg::NVC_ST_IDLE;
    endcase
  end

  // state is reset only while idle so a started operation completes across reset
  always_ff @(posedge mclk) begin
    if (rst && !busy) state <= nvc_pkg::NVC_ST_IDLE; // R17
    else state <= next_state; // R4
  end

  nvc_osc_timer #(
    .OSC_KHZ(OSC_KHZ)
  ) u_timer (
    .mclk(mclk),
    .rst(timerClear), // R17
    .oscTick(oscTick), // R18
    .start(goStart),
    .longTime(programModeField == nvc_pkg::NVC_MODE_ATOMIC), // R3
    .done(opDone)
  );

  // the array is updated at the end of the timed operation
  always_ff @(posedge mclk) begin
    if (opDone) begin
      if (programModeField == nvc_pkg::NVC_MODE_ERASE) mem[nvAddress] <= 8'hFF; // R1
      else if (programModeField == nvc_pkg::NVC_MODE_WRITE)
        mem[nvAddress] <= mem[nvAddress] & nvData; // R2 R6
      else mem[nvAddress] <= nvData; // R3 R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge mclk) begin
    if (rst) begin
      if (!busy) programModeField <= 2'b00; // R10
      readyIrqEnable <= 1'b0;
      programArmBit <= 1'b0;
      armCount <= 3'h0;
    end else begin
      if (modeWrite) programModeField <= ioWdata[`NVC_MODE_HI:`NVC_MODE_LO]; // R9
      if (wrCtrl) readyIrqEnable <= ioWdata[`NVC_BIT_RIE];
      if (wrCtrl && ioWdata[`NVC_BIT_ARM] && !goWrite) begin
        programArmBit <= 1'b1;
        armCount <= `NVC_ARM_CYCLES;
      end else if (armCount > 3'h1) begin
        armCount <= armCount - 3'h1;
      end else begin
        programArmBit <= 1'b0; // R7
        armCount <= 3'h0;
      end
      if (goValid) programArmBit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address and data registers
  always_ff @(posedge mclk) begin
    if (ioWrite && selAddr && !busy) nvAddress <= ioWdata[AW-1:0]; // R14 R15
  end

  always_ff @(posedge mclk) begin
    if (rst) nvData <= `NVC_DATA_RESET;
    else if (readStrobe) nvData <= mem[nvAddress]; // R13 R16
    else if (ioWrite && selData) nvData <= ioWdata; // R16
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu halt and outputs
  wire logic stallRaw;
  nvc_stall_counter u_stall (
    .mclk(mclk),
    .rst(rst),
    .load(goValid || readStrobe),
    .cycles(readStrobe ? `NVC_READ_STALL : `NVC_GO_STALL), // R12 R13
    .stall(stallRaw)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      ioRdata <= 8'h00;
      cpuStall <= 1'b0;
      readyIrq <= 1'b0;
    end else begin
      ioRdata <= ioRead ? next_rdata : 8'h00;
      cpuStall <= stallRaw;
      readyIrq <= readyIrqEnable && globalIrqEnable && (next_state == nvc_pkg::NVC_ST_IDLE); // R11
    end
  end
endmodule
`default_nettype wire

// ==== rtl/nvc_osc_timer.sv ====
// programming-time counter clocked by the calibrated oscillator tick
`default_nettype none
`include "nvc_regs.svh"
module nvc_osc_timer #(
  parameter int OSC_KHZ = `NVC_OSC_KHZ,
  parameter int ATOMIC_US = `NVC_ATOMIC_US,
  parameter int SPLIT_US = `NVC_SPLIT_US
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic oscTick,
  input wire logic start,
  input wire logic longTime,
  output logic done
);
  localparam int ATOMIC_TICKS = (OSC_KHZ * ATOMIC_US + 999) / 1000;
  localparam int SPLIT_TICKS = (OSC_KHZ * SPLIT_US + 999) / 1000;
  localparam int CW = $clog2(ATOMIC_TICKS + 1);
  initial begin
    if (ATOMIC_TICKS < 1 || SPLIT_TICKS < 1) $error("timer counts must be positive");
  end
  logic [CW-1:0] count;
  logic running;
  wire logic [CW-1:0] loadValue = longTime ? CW'(ATOMIC_TICKS) : CW'(SPLIT_TICKS);
  wire logic lastTick = running && oscTick && (count == CW'(1));
  // rst only reaches here while no operation runs, so a started count always completes
  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= '0;
      running <= 1'b0;
    end else if (start) begin
      count <= loadValue;
      running <= 1'b1;
    end else if (lastTick) begin
      running <= 1'b0;
    end else if (running && oscTick) begin
      count <= count - CW'(1);
    end
  end
  always_ff @(posedge mclk) begin
    done <= lastTick;
  end
endmodule
`default_nettype wire

// ==== rtl/nvc_stall_counter.sv ====
// counts down cpu halt cycles after a read or a program start
`default_nettype none
`include "nvc_regs.svh"
module nvc_stall_counter (
  input wire logic mclk,
  input wire logic rst,
  input wire logic load,
  input wire logic [2:0] cycles,
  output logic stall
);
  logic [2:0] left;
  always_ff @(posedge mclk) begin
    if (rst) left <= 3'h0;
    else if (load) left <= cycles;
    else if (left != 3'h0) left <= left - 3'h1;
  end
  assign stall = load || (left > 3'h1);
endmodule
`default_nettype wire

// ==== tb/nvc_cpu_model.sv ====
// cpu core model issuing io register reads and writes
`default_nettype none
module nvc_cpu_model (
  input wire logic mclk,
  input wire logic cpuStall,
  input wire logic [7:0] ioRdata,
  output logic [6:0] ioAddr,
  output logic dataSpace,
  output logic ioWrite,
  output logic ioRead,
  output logic [7:0] ioWdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ioAddr = 7'h00;
    dataSpace = 1'b0;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioWdata = 8'h00;
  end
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk);
    #1;
    while (cpuStall) begin // halted core issues nothing
      @(posedge mclk);
      #1;
    end
    ioAddr = a;
    dataSpace = a[5];
    ioWdata = d;
    ioWrite = w;
    ioRead = !w;
    @(posedge mclk);
    #1;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioAddr = ~a;
    ioWdata = ~d;
    q = ioRdata;
  endtask
endmodule
`default_nettype wire

// ==== tb/nvc_ctrl_assertions.sv ====
// port-level assertions for the eeprom access controller
`default_nettype none
module nvc_ctrl_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic oscTick,
  input wire logic globalIrqEnable,
  input wire logic [6:0] ioAddr,
  input wire logic dataSpace,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWdata,
  input wire logic [7:0] ioRdata,
  input wire logic cpuStall,
  input wire logic readyIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rd_idle; !ioRead |=> ioRdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("data outside read");
  property p_irq_off; !globalIrqEnable |=> !readyIrq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without global");
  property p_irq_fall; $fell(readyIrq) |->
    $past(ioWrite) || $past(ioWrite, 2) || !$past(globalIrqEnable); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
  property p_stall_max; cpuStall [*4] |=> !cpuStall; endproperty
  a_stall_max: assert property (p_stall_max) else $error("stall too long");
  property p_stall_min; $rose(cpuStall) |=> cpuStall; endproperty
  a_stall_min: assert property (p_stall_min) else $error("stall too short");
  property p_stall_cause; $rose(cpuStall) |-> $past(ioWrite) || $past(ioWrite, 2); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall uncaused");
  property p_addr_hi; ioRead && !dataSpace && ioAddr == 7'h1E |=> ioRdata[7:6] == 2'h0;
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("address top bits");
  property p_ds_view; ioRead && dataSpace && ioAddr < 7'h3C |=> ioRdata == 8'h00; endproperty
  a_ds_view: assert property (p_ds_view) else $error("data-space gap");
endmodule
bind nvc_eeprom_ctrl nvc_ctrl_assertions nvc_ctrl_assertions_inst (.mclk, .rst, .oscTick,
  .globalIrqEnable, .ioAddr, .dataSpace, .ioWrite, .ioRead, .ioWdata, .ioRdata, .cpuStall,
  .readyIrq);
`default_nettype wire

// ==== tb/nvc_eeprom_ctrl_tb_top.sv ====
// self-checking bench for the eeprom access controller
`default_nettype none
module nvc_eeprom_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, oscTick, globalIrqEnable, dataSpace, ioWrite, ioRead, cpuStall, readyIrq;
  logic [6:0] ioAddr;
  logic [7:0] ioWdata, ioRdata, q;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  nvc_eeprom_ctrl #(.DEPTH(64), .OSC_KHZ(1)) nvc_eeprom_ctrl_inst (.mclk, .rst, .oscTick,
    .globalIrqEnable, .ioAddr, .dataSpace, .ioWrite, .ioRead, .ioWdata, .ioRdata, .cpuStall,
    .readyIrq);
  nvc_cpu_model nvc_cpu_model_inst (.mclk, .cpuStall, .ioRdata, .ioAddr, .dataSpace,
    .ioWrite, .ioRead, .ioWdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    oscTick <= #1 (cyc % 8 == 0);
    if (cyc == 6000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    nvc_cpu_model_inst.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [6:0] a);
    nvc_cpu_model_inst.xfer(a, 1'b0, 8'h00, q);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(7'h1C);
      n++;
    end while (q[1] && n < 300);
    chk(q & 8'h02, 8'h00);
  endtask
  task automatic prog(input logic [1:0] m, input logic [5:0] a, input logic [7:0] d);
    wr(7'h1E, {2'h0, a});
    wr(7'h1D, d);
    wr(7'h1C, {2'h0, m, 4'hC});
    wr(7'h1C, {2'h0, m, 4'hA});
    rd(7'h1C);
    chk(q & 8'h02, {6'h00, m != 2'h3, 1'b0});
    wait_done();
    wr(7'h1E, {2'h0, a});
    wr(7'h1C, 8'h01);
    rd(7'h1D);
  endtask
  task automatic t_regs();
    rd(7'h1D);
    chk(q, 8'h00);
    wr(7'h1E, 8'hFF);
    rd(7'h3E);
    chk(q, 8'h3F);
    wr(7'h3D, 8'h5A);
    rd(7'h1D);
    chk(q, 8'h5A);
    rd(7'h2D);
    chk(q, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_modes();
    prog(2'h0, 6'h05, 8'hA5);
    chk(q, 8'hA5);
    prog(2'h1, 6'h05, 8'h00);
    chk(q, 8'hFF);
    prog(2'h2, 6'h05, 8'h3C);
    chk(q, 8'h3C);
    prog(2'h3, 6'h05, 8'h00);
    chk(q, 8'h3C);
    $display("t_modes done");
  endtask
  task automatic t_arm();
    wr(7'h1C, 8'h02);
    rd(7'h1C);
    chk(q & 8'h02, 8'h00);
    wr(7'h1C, 8'h04);
    repeat (6) @(posedge mclk);
    wr(7'h1C, 8'h02);
    rd(7'h1C);
    chk(q & 8'h06, 8'h00);
    $display("t_arm done");
  endtask
  task automatic t_busy();
    globalIrqEnable = 1'b1;
    wr(7'h1E, 8'h09);
    wr(7'h1D, 8'h77);
    wr(7'h1C, 8'h1C);
    wr(7'h1C, 8'h1A);
    wr(7'h1E, 8'h10);
    wr(7'h1C, 8'h39);
    rd(7'h1C);
    chk(q & 8'h3A, 8'h1A);
    chk({7'h00, readyIrq}, 8'h00);
    wait_done();
    rd(7'h1E);
    chk(q, 8'h09);
    rd(7'h1D);
    chk(q, 8'h77);
    chk({7'h00, readyIrq}, 8'h01);
    globalIrqEnable = 1'b0;
    @(posedge mclk);
    #1;
    chk({7'h00, readyIrq}, 8'h00);
    $display("t_busy done");
  endtask
  task automatic t_reset();
    wr(7'h1E, 8'h21);
    wr(7'h1D, 8'h66);
    wr(7'h1C, 8'h14);
    wr(7'h1C, 8'h12);
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    rd(7'h1C);
    chk(q & 8'h3A, 8'h12);
    wait_done();
    wr(7'h1C, 8'h01);
    rd(7'h1D);
    chk(q, 8'hFF);
    wr(7'h1C, 8'h10);
    rst = 1'b1;
    @(posedge mclk);
    #1 rst = 1'b0;
    rd(7'h1C);
    chk(q & 8'h30, 8'h00);
    rd(7'h1D);
    chk(q, 8'h00);
    $display("t_reset done");
  endtask
  initial begin
    rst = 1'b1;
    globalIrqEnable = 1'b0;
    repeat (20) @(posedge mclk);
    #1 rst = 1'b0;
    t_regs();
    t_modes();
    t_arm();
    t_busy();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
